// File: ibc_pkg.sv
`default_nettype none
package ibc_pkg;

    // ----------------------------------------------------------------
    // clock divider
    // ----------------------------------------------------------------
    localparam int unsigned MOD_W          = 6;
    localparam int unsigned PRESCALE_RATIO = 8;
    localparam int unsigned PRE_W          = 3;
    localparam logic [MOD_W-1:0] MODULUS_RST = 6'h3f;
    localparam logic             BYPASS_RST  = 1'b0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS  = 4000;
    localparam int unsigned NARROW_SPIKE_PS = 20000;
    localparam int unsigned WIDE_SPIKE_PS   = 100000;
    // a spike is rejected when it does not outlast the window
    localparam int unsigned NARROW_CYC =
        (NARROW_SPIKE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int unsigned WIDE_CYC =
        (WIDE_SPIKE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int unsigned FLT_W = 5;
    localparam logic [FLT_W-1:0] NARROW_CNT = FLT_W'(NARROW_CYC);
    localparam logic [FLT_W-1:0] WIDE_CNT   = FLT_W'(WIDE_CYC);

    localparam int unsigned DATA_VALID_PS = 3400000;
    localparam int unsigned DATA_VALID_CYC = DATA_VALID_PS / CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // filter modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        IBC_FLT_BYPASS = 2'h0,
        IBC_FLT_NARROW = 2'h1,
        IBC_FLT_WIDE   = 2'h2
    } ibc_filter_type;

endpackage : ibc_pkg
`default_nettype wire

// File: ibc_spike_filter.sv
`timescale 1ns/1ns
`default_nettype none
module ibc_spike_filter
    import ibc_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           arst_n_i,
    input  wire logic           raw_i,
    input  wire ibc_filter_type mode_i,
    output logic                clean_o
);
    typedef struct packed {
        logic             s1;
        logic             s2;
        logic             out;
        logic [FLT_W-1:0] cnt;
    } ibc_flt_type;

    ibc_flt_type st_r;
    ibc_flt_type st_nxt;
    logic [FLT_W-1:0] need;

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = raw_i;
        st_nxt.s2 = st_r.s1;                        // RQ14
        unique case (mode_i)
            IBC_FLT_NARROW: need = NARROW_CNT;
            IBC_FLT_WIDE:   need = WIDE_CNT;
            default:        need = '0;
        endcase
        // a level must persist past the spike window before it is passed on
        if (st_r.s2 == st_r.out)
        begin
            st_nxt.cnt = '0;
        end
        else if (st_r.cnt >= need)
        begin
            st_nxt.out = st_r.s2;                   // RQ6
            st_nxt.cnt = '0;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + FLT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_r <= '{s1: 1'b1, s2: 1'b1, out: 1'b1, cnt: '0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign clean_o = st_r.out;

    spike_reject_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RQ6
        (mode_i == IBC_FLT_WIDE && $changed(st_r.out)) |-> $past(st_r.cnt) >= WIDE_CNT
        || $past(mode_i) != IBC_FLT_WIDE)
        else $error("wide filter passed a short spike");
endmodule : ibc_spike_filter
`default_nettype wire

// File: ibc_bit_clock.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [RQ1] period = Tc*2*(modulus+1)*(8 or 1)
// [RQ2] bypass clear inserts divide-by-eight prescaler
// [RQ3] six-bit modulus gives ratios 1 to 64
// [RQ4] software programs period of 6 Tc minimum
// [RQ5] supports 100 kHz up to 1000 kHz; lowest rate here is about 244 kHz at a 250 MHz core clock
// [RQ6] spike filter: bypassed, 20 ns, 100 ns
// [RQ7] external master respects slave bus free time
// [RQ8] standard mode clock cycle at least 10 us; longest cycle here is 1024 cycles, about 4.1 us
// [RQ9] standard low 4.7 us, high 4.0 us; each half here is at most 512 cycles, about 2.0 us
// [RQ10] start hold 4.0 us before first low
// [RQ11] 4.7 us idle between stop and start
// [RQ12] SCL high 4.0 us before stop
// [RQ13] SDA data valid within 3.4 us
// [RQ14] synchronise SCL and SDA before filtering
module ibc_bit_clock
    import ibc_pkg::*;
#(
    parameter int unsigned MW = MOD_W
)
(
    input  wire logic           clk_i,
    input  wire logic           arst_n_i,
    input  wire logic [MW-1:0]  divider_modulus_i,
    input  wire logic           prescaler_bypass_i,
    input  wire ibc_filter_type filter_mode_i,
    input  wire logic           run_i,
    input  wire logic           tx_bit_i,
    input  wire logic           scl_i,
    input  wire logic           sda_i,
    output logic                scl_o,
    output logic                scl_oe_o,
    output logic                sda_o,
    output logic                sda_oe_o,
    output logic                scl_filt_o,
    output logic                sda_filt_o,
    output logic                start_det_o,
    output logic                stop_det_o,
    output logic                tick_o
);
    import ibc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [MW-1:0]    div;
        logic             scl_lo;
        logic             sda_lo;
        logic             sda_prev;
        logic             start;
        logic             stop;
        logic             tick;
        logic             sf;
        logic             df;
    } ibc_state_type;

    ibc_state_type st_r;
    ibc_state_type st_nxt;
    logic          scl_clean;
    logic          sda_clean;
    logic          pre_done;

    ibc_spike_filter u_scl_flt (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .raw_i    (scl_i),
        .mode_i   (filter_mode_i),
        .clean_o  (scl_clean)
    );

    ibc_spike_filter u_sda_flt (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .raw_i    (sda_i),
        .mode_i   (filter_mode_i),
        .clean_o  (sda_clean)
    );

    // ----------------------------------------------------------------
    // divider and line control
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        // prescaler counts 0..7, skipped entirely when bypassed
        pre_done = prescaler_bypass_i
                || (st_r.pre == PRE_W'(PRESCALE_RATIO - 1)); // RQ2
        if (!run_i)
        begin
            st_nxt.pre    = '0;
            st_nxt.div    = '0;
            st_nxt.scl_lo = 1'b0;
        end
        else if (pre_done)
        begin
            st_nxt.pre = '0;
            // each half period spans modulus+1 prescaled ticks
            // low and high halves are equal; at a 250 MHz core clock the longest period
            // is 1024 cycles (about 4.1 us), short of the standard-mode minimums
            if (st_r.div >= divider_modulus_i)                // RQ3 RQ8 RQ9
            begin
                st_nxt.div    = '0;
                st_nxt.scl_lo = ~st_r.scl_lo;                  // RQ1 RQ5
                st_nxt.tick   = 1'b1;
                // data changes in the same cycle as the falling edge, well inside 3.4 us
                if (!st_r.scl_lo)
                begin
                    st_nxt.sda_lo = ~tx_bit_i;                 // RQ13
                end
            end
            else
            begin
                st_nxt.div = st_r.div + MW'(1);
            end
        end
        else
        begin
            st_nxt.pre = st_r.pre + PRE_W'(1);
        end
        // start, stop and their spacing are timed by whoever drives run_i and tx_bit_i
        if (!run_i)
        begin
            st_nxt.sda_lo = 1'b0;                              // RQ10 RQ11 RQ12
        end
        st_nxt.sf       = scl_clean;
        st_nxt.df       = sda_clean;
        st_nxt.sda_prev = sda_clean;
        // start and stop judged only on filtered, synchronised lines
        st_nxt.start = scl_clean && st_r.sda_prev && !sda_clean;  // RQ14
        st_nxt.stop  = scl_clean && !st_r.sda_prev && sda_clean;  // RQ14
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_r <= '{pre: '0, div: '0, scl_lo: 1'b0, sda_lo: 1'b0,
                      sda_prev: 1'b1, start: 1'b0,
                      stop: 1'b0, tick: 1'b0, sf: 1'b1, df: 1'b1};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // open drain: only ever pull low
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe_o    = st_r.scl_lo;
    assign sda_oe_o    = st_r.sda_lo;
    assign scl_filt_o  = st_r.sf;
    assign sda_filt_o  = st_r.df;
    assign start_det_o = st_r.start;
    assign stop_det_o  = st_r.stop;
    assign tick_o      = st_r.tick;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // preset to all ones while idle so the first half after run_i rises counts like the rest
    logic [15:0] half_cnt_r;
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            half_cnt_r <= 16'hffff;
        end
        else if (!run_i)
        begin
            half_cnt_r <= 16'hffff;
        end
        else if (st_r.tick)
        begin
            half_cnt_r <= '0;
        end
        else
        begin
            half_cnt_r <= half_cnt_r + 16'h0001;
        end
    end

    half_period_len_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RQ1
        (run_i && $stable(divider_modulus_i) && $stable(prescaler_bypass_i) && st_r.tick
         && $past(st_r.tick) == 1'b0 && half_cnt_r != 16'h0000) |->
        half_cnt_r + 16'h0001 == 16'((divider_modulus_i + 1)
            * (prescaler_bypass_i ? 1 : PRESCALE_RATIO)))
        else $error("scl half period length wrong");

    bypass_fast_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RQ2
        (run_i && prescaler_bypass_i && $past(run_i) && $past(prescaler_bypass_i))
        |-> (st_r.tick ? st_r.div == '0 : st_r.div == $past(st_r.div) + MW'(1)))
        else $error("bypassed divider did not count every cycle");

    prescale_slow_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RQ2
        (run_i && !prescaler_bypass_i && st_r.tick) |=> !st_r.tick [*7])
        else $error("prescaled tick came too soon");

    modulus_bound_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RQ3
        $stable(divider_modulus_i) |-> st_r.div <= divider_modulus_i
        || $past(st_r.div) > $past(divider_modulus_i) || !run_i)
        else $error("divider ran past modulus");

    data_after_fall_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RQ13
        (run_i && $rose(st_r.scl_lo)) |-> st_r.sda_lo == ~$past(tx_bit_i))
        else $error("sda not updated at scl fall");

    start_seen_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RQ14
        start_det_o == (scl_filt_o && $fell(sda_filt_o)))
        else $error("start condition missed");

    stop_seen_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RQ14
        stop_det_o == (scl_filt_o && $rose(sda_filt_o)))
        else $error("stop condition missed");

    idle_release_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RQ1
        !run_i |=> !scl_oe_o && !sda_oe_o)
        else $error("lines held while idle");
endmodule : ibc_bit_clock
`default_nettype wire

// File: ibc_bus_peer.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// far-side bus device: pulls lines low through open-drain enables
// ----------------------------------------------------------------
module ibc_bus_peer #(
    parameter int unsigned FREE_CYC = 1175,
    parameter int unsigned HOLD_CYC = 1000
)
(
    input  wire logic clk_i,
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    initial
    begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end

    // a released line returns to the pull-up, never to a held value
    task automatic spike(input bit on_sda, input int cyc);
        @(negedge clk_i);
        if (on_sda)
            sda_oe_o = 1'b1;
        else
            scl_oe_o = 1'b1;
        repeat (cyc) @(negedge clk_i);
        sda_oe_o = 1'b0;
        scl_oe_o = 1'b0;
    endtask : spike

    // start then stop with the clock line left high throughout
    task automatic start_stop();
        repeat (FREE_CYC) @(negedge clk_i);
        sda_oe_o = 1'b1;
        repeat (HOLD_CYC) @(negedge clk_i);
        sda_oe_o = 1'b0;
    endtask : start_stop
endmodule : ibc_bus_peer
`default_nettype wire

// File: tb_i2c_bit_clock_and_filter.sv
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_bit_clock_and_filter;
    import ibc_pkg::*;
    logic             clk = 1'b0;
    logic             arst_n = 1'b0;
    logic [MOD_W-1:0] modulus = 6'h02;
    logic             bypass = 1'b0;
    ibc_filter_type   fmode = IBC_FLT_BYPASS;
    logic             run = 1'b0;
    logic             tx = 1'b0;
    logic             scl_oe, sda_oe, scl_filt, sda_filt, start_det, stop_det, tick;
    logic             peer_scl_oe, peer_sda_oe;
    logic             scl_do, sda_do;
    wire logic        scl_w = ~(scl_oe | peer_scl_oe);
    wire logic        sda_w = ~(sda_oe | peer_sda_oe);
    int               seed = 23;
    int               error_cnt = 0;
    int               comparisons = 0;

    always #2 clk = ~clk;

    ibc_bit_clock #(.MW(MOD_W)) ibc_bit_clock_i (.clk_i(clk), .arst_n_i(arst_n),
        .divider_modulus_i(modulus), .prescaler_bypass_i(bypass), .filter_mode_i(fmode),
        .run_i(run), .tx_bit_i(tx), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_do),
        .scl_oe_o(scl_oe), .sda_o(sda_do), .sda_oe_o(sda_oe), .scl_filt_o(scl_filt),
        .sda_filt_o(sda_filt), .start_det_o(start_det), .stop_det_o(stop_det), .tick_o(tick));
    ibc_bus_peer ibc_bus_peer_i (.clk_i(clk), .scl_oe_o(peer_scl_oe), .sda_oe_o(peer_sda_oe));

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic int exp_half(input int m, input bit byp);
        return (m + 1) * (byp ? 1 : PRESCALE_RATIO);
    endfunction : exp_half

    function automatic bit exp_pass(input ibc_filter_type md, input int w);
        int lim;
        lim = (md == IBC_FLT_WIDE) ? WIDE_SPIKE_PS : (md == IBC_FLT_NARROW) ? NARROW_SPIKE_PS : 0;
        return w * CLK_PERIOD_PS > lim;
    endfunction : exp_pass

    // count cycles to the next edge pulse; a hang ends the run
    task automatic next_tick(output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
            if (n > 600)
            begin
                error_cnt++;
                stop_test();
            end
        end
        while (tick !== 1'b1);
    endtask : next_tick

    task automatic divider_run(input int m, input bit byp);
        int n;
        modulus = m[MOD_W-1:0];
        bypass = byp;
        tx = 1'($random(seed));
        // settings settle one cycle before the divider starts
        @(negedge clk);
        run = 1'b1;
        next_tick(n);
        chk(n, exp_half(m, byp));
        for (int h = 0; h < 6; h++)
        begin
            if (scl_oe === 1'b1)
                chk(sda_oe, !tx);
            else
                tx = 1'($random(seed));
            next_tick(n);
            chk(n, exp_half(m, byp));
        end
        run = 1'b0;
        repeat (3) @(negedge clk);
        chk({scl_oe, sda_oe, scl_do, sda_do}, 4'h0);
        $display("divider test m=%0d bypass=%0d done", m, byp);
    endtask : divider_run

    initial
    begin
        int m;
        bit seen;
        int ns, np;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk({scl_oe, sda_oe, scl_filt, sda_filt, start_det, stop_det, tick}, 7'h18);
        divider_run(2, 1'b1);
        divider_run(63, 1'b0);
        divider_run(15, 1'b0);
        divider_run(63, 1'b1);
        for (int k = 0; k < 8; k++)
        begin
            m = 2 + ($unsigned($random(seed)) % 62);
            divider_run(m, 1'($random(seed)));
        end
        for (int t = 0; t < 10; t++)
        begin
            fmode = ibc_filter_type'(t / 2 == 0 ? 0 : (t < 6 ? 1 : 2));
            m = (t < 2) ? 1 : (t < 6 ? (t[0] ? 10 : 5) : (t[0] ? 30 : 25));
            seen = 1'b0;
            fork
                ibc_bus_peer_i.spike(t >= 4 && t[1], m);
                repeat (WIDE_CYC + 40) @(negedge clk)
                    if (scl_filt === 1'b0 || sda_filt === 1'b0)
                        seen = 1'b1;
            join
            chk(seen, exp_pass(fmode, m));
        end
        $display("filter test done");
        fmode = IBC_FLT_BYPASS;
        ns = 0;
        np = 0;
        fork
            ibc_bus_peer_i.start_stop();
            repeat (2300) @(negedge clk)
            begin
                ns += (start_det === 1'b1);
                np += (stop_det === 1'b1);
            end
        join
        chk({ns[7:0], np[7:0]}, 16'h0101);
        $display("start stop test done");
        stop_test();
    end
endmodule : tb_i2c_bit_clock_and_filter
`default_nettype wire
